// [hdl/srs_reset_one_shot.sv]
// Notes on behaviour
// - Supply low or manual edge asserts reset
// - Hold reset for option-selected supply timeout
// - Manual edge gives fixed-length reset pulse
// - Edges during pulse never retrigger it
// - Falling edges during rising debounce restart it, never fire
// - Re-arm after input high for debounce
// - Option selects open-drain or push-pull drive
// - Floating manual input reads high, inactive
`timescale 1ns/1ps
`default_nettype none

module srs_reset_one_shot
  import srs_pkg::*;
#(
  parameter srs_cnt_t SHORT_HOLD = srs_cnt_t'(srs_pkg::SHORT_HOLD_CYC),
  parameter srs_cnt_t LONG_HOLD  = srs_cnt_t'(srs_pkg::LONG_HOLD_CYC),
  parameter srs_cnt_t MAN_PULSE  = srs_cnt_t'(srs_pkg::MANUAL_PULSE_CYC),
  parameter srs_cnt_t DEBOUNCE   = srs_cnt_t'(srs_pkg::DEBOUNCE_CYC)
) (
  // Clock and reset
  input  wire logic          ref_clk,
  input  wire logic          resetn,
  // Supply monitor and options
  input  wire logic          supply_low,
  input  wire logic          long_timeout_option,
  input  wire logic          push_pull_option,
  // Manual input (pull-up modelled as undriven means high)
  input  wire logic          pushbutton_trigger_n,
  input  wire logic          pushbutton_driven,
  // Reset output pin
  output var srs_pkg::srs_pin_t reset_out_n
);

  // ****************************************************************
  // Input conditioning
  // ****************************************************************
  logic     btn_lvl;          // Effective manual level
  logic     btn_prev_q;       // Level one cycle ago
  logic     btn_fall;         // Falling edge seen
  logic     btn_rise;         // Rising edge seen
  srs_cnt_t sup_cnt_q;        // Supply hold countdown
  logic     sup_hold_q;       // Supply source asserting
  srs_man_t man_q;            // Manual one-shot state
  srs_cnt_t man_cnt_q;        // Manual timer
  logic     rst_q;            // Registered reset request

  // Undriven input reads high through the pull-up
  assign btn_lvl  = pushbutton_driven ? pushbutton_trigger_n : 1'b1;
  assign btn_fall = btn_prev_q & ~btn_lvl;
  assign btn_rise = ~btn_prev_q & btn_lvl;

  // Previous level, reset high so no false edge
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      btn_prev_q <= 1'b1;
    end else begin
      btn_prev_q <= btn_lvl;
    end
  end

  // ****************************************************************
  // Supply source
  // ****************************************************************
  // Load timer while low, count down after recovery
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      sup_cnt_q  <= '0;
      sup_hold_q <= 1'b1;
    end else if (supply_low) begin
      sup_hold_q <= 1'b1;
      sup_cnt_q  <= long_timeout_option ? LONG_HOLD : SHORT_HOLD;
    end else if (sup_hold_q) begin
      // Hold until the full period has elapsed
      if (sup_cnt_q <= srs_cnt_t'(1)) begin
        sup_hold_q <= 1'b0;
        sup_cnt_q  <= '0;
      end else begin
        sup_cnt_q <= sup_cnt_q - srs_cnt_t'(1);
      end
    end
  end

  // ****************************************************************
  // Manual one-shot
  // ****************************************************************
  // Armed -> pulse -> wait for release -> debounce -> armed
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      man_q     <= SRS_ARMED;
      man_cnt_q <= '0;
    end else begin
      unique case (man_q)
        SRS_ARMED: begin
          // First falling edge fires the pulse
          if (btn_fall) begin
            man_q     <= SRS_PULSE;
            man_cnt_q <= MAN_PULSE - srs_cnt_t'(1);
          end
        end
        SRS_PULSE: begin
          // Fixed length, edges ignored
          if (man_cnt_q == '0) begin
            man_q <= btn_lvl ? SRS_DEBOUNCE : SRS_WAIT_RISE;
            man_cnt_q <= DEBOUNCE - srs_cnt_t'(1);
          end else begin
            man_cnt_q <= man_cnt_q - srs_cnt_t'(1);
          end
          // Input level at pulse end picks debounce if high, else wait for rise
        end
        SRS_WAIT_RISE: begin
          // Input still held low after pulse
          if (btn_lvl) begin
            man_q     <= SRS_DEBOUNCE;
            man_cnt_q <= DEBOUNCE - srs_cnt_t'(1);
          end
        end
        SRS_DEBOUNCE: begin
          // Any low restarts the high-time requirement
          if (!btn_lvl) begin
            man_q <= SRS_WAIT_RISE;
          end else if (man_cnt_q == '0) begin
            man_q <= SRS_ARMED;
          end else begin
            man_cnt_q <= man_cnt_q - srs_cnt_t'(1);
          end
        end
      endcase
    end
  end

  // ****************************************************************
  // Output pin
  // ****************************************************************
  // Either source asserts reset
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      rst_q <= 1'b1;
    end else begin
      rst_q <= supply_low | sup_hold_q | (man_q == SRS_PULSE) | ((man_q == SRS_ARMED) & btn_fall);
    end
  end

  // Open-drain releases when idle, push-pull drives high
  // One assignment for the whole pin keeps a single driver
  assign reset_out_n = '{o: ~rst_q, oe: rst_q | push_pull_option};

  // ****************************************************************
  // Checks
  // ****************************************************************
  // Supply low shows on the pin one cycle later
  a_supply_asserts: assert property (@(posedge ref_clk) disable iff (!resetn)
    supply_low |=> !reset_out_n.o)
    else $error("supply low did not assert reset");

  // Armed falling edge drives the pin low and enters the pulse
  a_manual_fires: assert property (@(posedge ref_clk) disable iff (!resetn)
    (man_q == SRS_ARMED && btn_fall && !supply_low) |=> !reset_out_n.o && (man_q == SRS_PULSE))
    else $error("manual edge did not fire pulse");

  // Pulse timer is loaded with the full manual period
  a_pulse_load: assert property (@(posedge ref_clk) disable iff (!resetn)
    (man_q == SRS_ARMED && btn_fall) |=> man_cnt_q == MAN_PULSE - srs_cnt_t'(1))
    else $error("manual pulse timer not loaded");

  // Pulse leaves once its timer has run out, whatever the input does
  a_pulse_ends: assert property (@(posedge ref_clk) disable iff (!resetn)
    (man_q == SRS_PULSE && man_cnt_q == '0) |=> man_q != SRS_PULSE)
    else $error("manual pulse did not end");

  // A bounce inside the pulse never reloads the timer
  a_pulse_noextend: assert property (@(posedge ref_clk) disable iff (!resetn)
    (man_q == SRS_PULSE && btn_fall) |=> (man_cnt_q < $past(man_cnt_q) || man_q != SRS_PULSE))
    else $error("pulse was retriggered");

  // A low in debounce aborts it instead of firing
  a_debounce_ignore: assert property (@(posedge ref_clk) disable iff (!resetn)
    (man_q == SRS_DEBOUNCE && btn_fall) |=> man_q == SRS_WAIT_RISE)
    else $error("falling edge in debounce not ignored");

  // Arming is reached only from a debounce that stayed high
  a_rearm_after: assert property (@(posedge ref_clk) disable iff (!resetn)
    (man_q == SRS_ARMED && $past(man_q) != SRS_ARMED) |-> $past(man_q) == SRS_DEBOUNCE && $past(btn_lvl))
    else $error("re-armed without debounce");

  // Open-drain never drives the high level
  a_od_release: assert property (@(posedge ref_clk) disable iff (!resetn)
    (!push_pull_option && reset_out_n.o) |-> !reset_out_n.oe)
    else $error("open-drain drove high");

  // An asserted reset is always actively pulled low
  a_low_driven: assert property (@(posedge ref_clk) disable iff (!resetn)
    !reset_out_n.o |-> reset_out_n.oe)
    else $error("asserted reset not driven");

  // Push-pull drives the pin at all times
  a_pp_drives: assert property (@(posedge ref_clk) disable iff (!resetn)
    push_pull_option |-> reset_out_n.oe)
    else $error("push-pull output released");

  // A floating input reads high and cannot fire
  a_float_quiet: assert property (@(posedge ref_clk) disable iff (!resetn)
    (!pushbutton_driven && man_q == SRS_ARMED) |=> man_q == SRS_ARMED)
    else $error("undriven input fired pulse");

  // Recovery starts the full period chosen while supply was low
  a_supply_restart: assert property (@(posedge ref_clk) disable iff (!resetn)
    (supply_low ##1 !supply_low) |->
      sup_hold_q && sup_cnt_q == ($past(long_timeout_option) ? LONG_HOLD : SHORT_HOLD))
    else $error("supply timeout not restarted");

  // Supply hold keeps the pin low
  a_hold_keeps: assert property (@(posedge ref_clk) disable iff (!resetn)
    sup_hold_q |=> !reset_out_n.o)
    else $error("reset released during hold");

  // Supply hold ends when its timer runs out
  a_supply_expiry: assert property (@(posedge ref_clk) disable iff (!resetn)
    (sup_hold_q && !supply_low && sup_cnt_q <= srs_cnt_t'(1)) |=> !sup_hold_q)
    else $error("supply hold did not expire");

  // With no source active the pin is released
  a_idle_release: assert property (@(posedge ref_clk) disable iff (!resetn)
    (!supply_low && !sup_hold_q && man_q != SRS_PULSE && !(man_q == SRS_ARMED && btn_fall))
      |=> reset_out_n.o)
    else $error("reset held with no source");

endmodule : srs_reset_one_shot

`default_nettype wire

// [hdl/srs_pkg.sv]
package srs_pkg;

  // ****************************************************************
  // Clock and timing
  // ****************************************************************
  localparam int unsigned CLK_PERIOD_NS       = 25;       // 40 MHz reference
  localparam int unsigned SHORT_HOLD_MS       = 150;      // Short supply hold, least
  localparam int unsigned LONG_HOLD_MS        = 1200;     // Long supply hold, least
  localparam int unsigned MANUAL_PULSE_MS     = 150;      // Manual one-shot, least
  localparam int unsigned DEBOUNCE_MS         = 150;      // Rising debounce, least
  localparam longint unsigned CYC_PER_MS      = 64'd1000000 / CLK_PERIOD_NS;
  localparam longint unsigned SHORT_HOLD_CYC  = SHORT_HOLD_MS * CYC_PER_MS;
  localparam longint unsigned LONG_HOLD_CYC   = LONG_HOLD_MS * CYC_PER_MS;
  localparam longint unsigned MANUAL_PULSE_CYC = MANUAL_PULSE_MS * CYC_PER_MS;
  localparam longint unsigned DEBOUNCE_CYC    = DEBOUNCE_MS * CYC_PER_MS;
  localparam int unsigned CNT_W               = 32;       // Timer width

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef logic [CNT_W-1:0] srs_cnt_t;

  // Manual one-shot states
  typedef enum logic [1:0] {
    SRS_ARMED,
    SRS_PULSE,
    SRS_WAIT_RISE,
    SRS_DEBOUNCE
  } srs_man_t;

  // Reset output pin
  typedef struct packed {
    logic o;   // Level driven
    logic oe;  // Drive enable
  } srs_pin_t;

endpackage : srs_pkg

// [tb/srs_host_model.sv]
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// Host reset input with board pull-up
// ****************************************************************
module srs_host_model
  import srs_pkg::*;
(
  // Pin from the supervisor
  input  wire srs_pkg::srs_pin_t reset_out_n,
  // Level seen by the host
  output wire logic              host_rst_n
);
  // A released line is pulled high by the board resistor
  assign host_rst_n = reset_out_n.oe ? reset_out_n.o : 1'b1;
endmodule : srs_host_model

`default_nettype wire

// [tb/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin errors++; \
  $display("unexpected %s: expected %0b seen %0b", nm, e, g); end end

// ****************************************************************
// Bench for the supervisory reset block
// ****************************************************************
module testbench;
  import srs_pkg::*;
  localparam srs_cnt_t HS = 32'h14;   // Short hold
  localparam srs_cnt_t HL = 32'h50;   // Long hold
  localparam srs_cnt_t MP = 32'ha;    // Manual pulse
  localparam srs_cnt_t DB = 32'ha;    // Debounce
  logic      ref_clk    = 1'b0;
  logic      resetn     = 1'b0;
  logic      supply_low = 1'b1;       // Power-on: supply below trip level
  logic      long_opt   = 1'b0;
  logic      pp_opt     = 1'b1;
  logic      btn_n      = 1'b1;
  logic      btn_drv    = 1'b1;
  srs_pin_t  rst_pin;
  wire logic host_rst_n;
  int        errors     = 0;
  int        n_compared = 0;

  // Clock, 25 ns period
  always #12.5 ref_clk = ~ref_clk;

  srs_reset_one_shot #(.SHORT_HOLD(HS), .LONG_HOLD(HL), .MAN_PULSE(MP), .DEBOUNCE(DB)) i_srs_reset_one_shot (
    .ref_clk(ref_clk), .resetn(resetn), .supply_low(supply_low), .long_timeout_option(long_opt),
    .push_pull_option(pp_opt), .pushbutton_trigger_n(btn_n), .pushbutton_driven(btn_drv),
    .reset_out_n(rst_pin));
  srs_host_model i_srs_host_model (.reset_out_n(rst_pin), .host_rst_n(host_rst_n));

  // Host level must stay at exp for n cycles
  task automatic hold_lvl(input string nm, input logic exp, input int n);
    repeat (n) begin
      @(negedge ref_clk);
      `CHK(nm, exp, host_rst_n)
    end
  endtask : hold_lvl

  // Bounded wait for the host level; running out ends the run
  task automatic wait_lvl(input string nm, input logic exp, input int n);
    int k;
    k = 0;
    while (host_rst_n !== exp && k < n) begin
      @(negedge ref_clk);
      k++;
    end
    `CHK(nm, exp, host_rst_n)
    if (host_rst_n !== exp) end_of_test();
  endtask : wait_lvl

  // Supply dip and recovery under one option setting
  task automatic t_supply(input logic lopt, input logic pp, input int hold);
    long_opt   = lopt;
    pp_opt     = pp;
    supply_low = 1'b1;
    wait_lvl("supply assert", 1'b0, 3);
    repeat (5) @(negedge ref_clk);
    supply_low = 1'b0;
    repeat (hold / 2) @(negedge ref_clk);
    supply_low = 1'b1;                      // Relapse mid-count
    hold_lvl("relapse low", 1'b0, 3);
    supply_low = 1'b0;
    hold_lvl("supply hold", 1'b0, hold);
    wait_lvl("supply release", 1'b1, 4);
    `CHK("drive enable", pp, rst_pin.oe)
    $display("supply test done, long %0b push-pull %0b", lopt, pp);
  endtask : t_supply

  // Manual one-shot with bounce in pulse, in debounce and early re-press
  task automatic t_manual();
    btn_n = 1'b0;
    wait_lvl("manual assert", 1'b0, 3);
    btn_n = 1'b1;
    @(negedge ref_clk);
    btn_n = 1'b0;                           // Bounce inside the pulse
    hold_lvl("manual pulse", 1'b0, MP - 1);
    wait_lvl("pulse end", 1'b1, 1);
    hold_lvl("held low", 1'b1, 20);
    btn_n = 1'b1;
    repeat (4) @(negedge ref_clk);
    btn_n = 1'b0;                           // Fall in debounce
    hold_lvl("debounce fall", 1'b1, 6);
    btn_n = 1'b1;
    repeat (DB - 4) @(negedge ref_clk);
    btn_n = 1'b0;                           // Fall before debounce ends
    hold_lvl("early fall", 1'b1, 6);
    btn_n = 1'b1;
    repeat (DB + 4) @(negedge ref_clk);
    btn_n = 1'b0;
    wait_lvl("rearmed", 1'b0, 3);
    wait_lvl("second end", 1'b1, MP + 4);
    btn_n = 1'b1;
    repeat (DB + 4) @(negedge ref_clk);
    $display("manual test done");
  endtask : t_manual

  // Floating manual input never triggers
  task automatic t_float();
    btn_drv = 1'b0;
    btn_n   = 1'b0;
    hold_lvl("floating input", 1'b1, 20);
    btn_n   = 1'b1;
    btn_drv = 1'b1;
    $display("floating test done");
  endtask : t_float

  // Print counts and verdict, then stop
  task automatic end_of_test();
    $display("compared %0d, errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_of_test

  // Main sequence
  initial begin
    repeat (5) @(negedge ref_clk);
    `CHK("in reset", 1'b0, host_rst_n)
    resetn = 1'b1;
    t_supply(1'b0, 1'b1, HS);
    t_supply(1'b1, 1'b0, HL);
    t_supply(1'b0, 1'b0, HS);
    t_manual();
    t_float();
    end_of_test();
  end
endmodule : testbench

`default_nettype wire
